/* File: logic/smd_desc_rom.sv */
// Constant descriptor table of the sector map detection sequence
`timescale 1ns/1ns
`default_nettype none
module smd_desc_rom #(
	parameter int IDX_W = smd_pkg::IDX_W
) (
	input  wire logic [IDX_W-1:0] idx,
	output logic      [31:0]      dword
);
	// Fixed contents, no write path
	always_comb
	begin
		if (int'(idx) < smd_pkg::TBL_DEPTH)
			dword = smd_pkg::DESC_TABLE[idx]; // [RULE_15]
		else
			dword = smd_pkg::WORD_ZERO;
	end
endmodule : smd_desc_rom
`default_nettype wire

/* File: logic/smd_device.sv */
// Device end: serves descriptor dwords and configuration register reads
`timescale 1ns/1ns
`default_nettype none
module smd_device (
	input  wire logic  pclk,
	input  wire logic  presetn,
	smd_link_if.dev    link,
	input  wire logic [7:0] third_nonvolatile_config_reg,
	input  wire logic [7:0] first_nonvolatile_config_reg
);
	typedef struct packed {
		logic        tbl_ack;
		logic [31:0] tbl_data;
		logic        reg_ack;
		logic [7:0]  reg_data;
	} smd_dev_t;

	smd_dev_t    s_q;
	smd_dev_t    s_d;
	logic [31:0] rom_dword;

	// Descriptors carry variable address length and latency, opcode,
	// ones in reserved fields, command type and end flag
	smd_desc_rom #(.IDX_W(smd_pkg::IDX_W)) u_rom (
		.idx   (link.tbl_idx), // [RULE_01] [RULE_03] [RULE_04] [RULE_05] [RULE_06]
		.dword (rom_dword) // [RULE_07] [RULE_08] [RULE_09] [RULE_10]
	);

	// ********************************************************************
	// One acknowledge pulse per request
	// ********************************************************************
	always_comb
	begin
		s_d = s_q;
		s_d.tbl_ack = link.tbl_req & ~s_q.tbl_ack;
		if (link.tbl_req & ~s_q.tbl_ack)
			s_d.tbl_data = rom_dword; // [RULE_15]
		s_d.reg_ack = link.reg_req & ~s_q.reg_ack;
		if (link.reg_req & ~s_q.reg_ack)
		begin
			s_d.reg_data = smd_pkg::UNMAPPED_BYTE;
			if (link.reg_op == smd_pkg::DETECT_OPCODE) // [RULE_05]
			begin
				if (link.reg_addr == smd_pkg::ADDR_CFG3)
					s_d.reg_data = third_nonvolatile_config_reg; // [RULE_09]
				else if (link.reg_addr == smd_pkg::ADDR_CFG1)
					s_d.reg_data = first_nonvolatile_config_reg;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign link.tbl_ack  = s_q.tbl_ack;
	assign link.tbl_data = s_q.tbl_data;
	assign link.reg_ack  = s_q.reg_ack;
	assign link.reg_data = s_q.reg_data;
endmodule : smd_device
`default_nettype wire

/* File: logic/smd_host.sv */
// Host end: walks the detection descriptors and forms the sector map index
//
// Functional notes
// [RULE_01] First descriptor mask 08h keeps bit 3
// [RULE_02] Bit 3: zero hybrid, one uniform map
// [RULE_03] Address length field reads 11b, variable
// [RULE_04] Latency field reads 1111b, variable latency
// [RULE_05] Detection instruction is register read 65h
// [RULE_06] Reserved fields read as all ones
// [RULE_07] Bit 1 zero marks command descriptor
// [RULE_08] First two not last; keep parsing
// [RULE_09] First descriptor address 04h, third config register
// [RULE_10] Second descriptor mask 04h keeps bit 2
// [RULE_11] Placement bit zero: parameter sectors bottom
// [RULE_12] Placement bit one: parameter sectors top
// [RULE_13] Second descriptor reads first config register 02h
// [RULE_14] Concatenate masked bits MSB first; reject unsupported
// [RULE_15] Descriptor contents constant, unchanged by writes
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module smd_host #(
	parameter int INDEX_W = smd_pkg::INDEX_W
) (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	smd_link_if.host                             link,
	input  wire logic [smd_pkg::APB_ADDR_W-1:0]  paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr
);
	typedef struct packed {
		smd_pkg::smd_state_t        st;
		logic [smd_pkg::IDX_W-1:0]  dw;
		logic [7:0]                 mask;
		logic [7:0]                 op;
		logic                       last;
		logic                       tbl_req;
		logic                       reg_req;
		logic [31:0]                reg_addr;
		logic [INDEX_W-1:0]         index;
		logic [3:0]                 nbits;
		logic                       busy;
		logic                       done;
		logic                       err;
		logic                       pready;
		logic                       pslverr;
		logic [31:0]                prdata;
	} smd_host_t;

	smd_host_t s_q;
	smd_host_t s_d;

	function automatic logic masked_bit(input logic [7:0] data, input logic [7:0] mask);
		masked_bit = |(data & mask);
	endfunction : masked_bit

	function automatic logic [31:0] status_word(input smd_host_t s);
		status_word = smd_pkg::WORD_ZERO;
		status_word[smd_pkg::ST_BUSY] = s.busy;
		status_word[smd_pkg::ST_DONE] = s.done;
		status_word[smd_pkg::ST_ERR]  = s.err;
		status_word[smd_pkg::ST_IDX_LSB +: INDEX_W] = s.index;
		status_word[smd_pkg::ST_UNIFORM] = s.done & s.index[INDEX_W-1];
		status_word[smd_pkg::ST_TOP]     = s.done & s.index[INDEX_W-2];
	endfunction : status_word

	logic               start_wr;
	logic               new_bit;
	logic [INDEX_W-1:0] new_index;

	assign start_wr  = psel & penable & s_q.pready & pwrite & ~s_q.pslverr
		& (paddr == smd_pkg::OFS_CTRL) & pwdata[smd_pkg::CTRL_START_BIT];
	assign new_bit   = masked_bit(link.reg_data, s_q.mask); // [RULE_01] [RULE_10]
	assign new_index = {s_q.index[INDEX_W-2:0], new_bit}; // [RULE_14]

	always_comb
	begin
		s_d = s_q;

		// ****************************************************************
		// APB slave, no wait states
		// ****************************************************************
		s_d.pready  = psel & ~penable;
		s_d.pslverr = 1'h0;
		s_d.prdata  = smd_pkg::WORD_ZERO;
		if (psel & ~penable)
		begin
			if (paddr == smd_pkg::OFS_STATUS)
			begin
				if (!pwrite)
					s_d.prdata = status_word(s_q); // [RULE_02] [RULE_11] [RULE_12]
			end
			else if (paddr != smd_pkg::OFS_CTRL)
				s_d.pslverr = 1'h1;
		end

		// ****************************************************************
		// Detection sequence
		// ****************************************************************
		case (s_q.st)
			smd_pkg::SMD_IDLE:
			begin
				if (start_wr)
				begin
					s_d.busy    = 1'h1;
					s_d.done    = 1'h0;
					s_d.err     = 1'h0;
					s_d.index   = '0;
					s_d.nbits   = '0;
					s_d.dw      = '0;
					s_d.tbl_req = 1'h1;
					s_d.st      = smd_pkg::SMD_FETCH_CMD;
				end
			end
			smd_pkg::SMD_FETCH_CMD:
			begin
				if (link.tbl_ack)
				begin
					if (link.tbl_data[smd_pkg::TYPE_BIT] != smd_pkg::DESC_IS_CMD) // [RULE_07]
					begin
						s_d.tbl_req = 1'h0;
						s_d.busy    = 1'h0;
						s_d.err     = 1'h1;
						s_d.done    = 1'h1;
						s_d.st      = smd_pkg::SMD_IDLE;
					end
					else
					begin
						s_d.mask = link.tbl_data[smd_pkg::MASK_LSB +: 8];
						s_d.op   = link.tbl_data[smd_pkg::OPCODE_LSB +: 8]; // [RULE_05]
						s_d.last = link.tbl_data[smd_pkg::END_BIT]; // [RULE_08]
						s_d.dw   = s_q.dw + 1'h1;
						s_d.st   = smd_pkg::SMD_FETCH_ADDR;
					end
				end
			end
			smd_pkg::SMD_FETCH_ADDR:
			begin
				if (link.tbl_ack)
				begin
					s_d.reg_addr = link.tbl_data; // [RULE_09] [RULE_13]
					s_d.tbl_req  = 1'h0;
					s_d.reg_req  = 1'h1;
					s_d.st       = smd_pkg::SMD_READ_REG;
				end
			end
			smd_pkg::SMD_READ_REG:
			begin
				if (link.reg_ack)
				begin
					s_d.reg_req = 1'h0;
					s_d.index   = new_index; // [RULE_14]
					s_d.nbits   = s_q.nbits + 1'h1;
					if (s_q.last)
					begin
						s_d.busy = 1'h0;
						s_d.done = 1'h1;
						s_d.err  = (int'(s_q.nbits) != INDEX_W - 1)
							| (new_index > smd_pkg::MAX_INDEX); // [RULE_14]
						s_d.st   = smd_pkg::SMD_IDLE;
					end
					else if (int'(s_q.nbits) >= INDEX_W - 1)
					begin
						s_d.busy = 1'h0;
						s_d.done = 1'h1;
						s_d.err  = 1'h1;
						s_d.st   = smd_pkg::SMD_IDLE;
					end
					else
					begin
						s_d.dw      = s_q.dw + 1'h1; // [RULE_08]
						s_d.tbl_req = 1'h1;
						s_d.st      = smd_pkg::SMD_FETCH_CMD;
					end
				end
			end
			default:
			begin
				s_d = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign link.tbl_req  = s_q.tbl_req;
	assign link.tbl_idx  = s_q.dw;
	assign link.reg_req  = s_q.reg_req;
	assign link.reg_op   = s_q.op;
	assign link.reg_addr = s_q.reg_addr;
	assign prdata        = s_q.prdata;
	assign pready        = s_q.pready;
	assign pslverr       = s_q.pslverr;
endmodule : smd_host
`default_nettype wire

/* File: logic/smd_link_if.sv */
// Interface joining the parameter read path and the detection register reads
`timescale 1ns/1ns
`default_nettype none
interface smd_link_if;
	logic                        tbl_req;
	logic [smd_pkg::IDX_W-1:0]   tbl_idx;
	logic                        tbl_ack;
	logic [31:0]                 tbl_data;
	logic                        reg_req;
	logic [7:0]                  reg_op;
	logic [31:0]                 reg_addr;
	logic                        reg_ack;
	logic [7:0]                  reg_data;

	modport dev (
		input  tbl_req, tbl_idx, reg_req, reg_op, reg_addr,
		output tbl_ack, tbl_data, reg_ack, reg_data
	);
	modport host (
		output tbl_req, tbl_idx, reg_req, reg_op, reg_addr,
		input  tbl_ack, tbl_data, reg_ack, reg_data
	);
endinterface : smd_link_if
`default_nettype wire

/* File: logic/smd_pkg.sv */
// Package of constants and types shared by the sector map detection ends
`default_nettype none
package smd_pkg;

	// ********************************************************************
	// Descriptor fields
	// ********************************************************************
	localparam logic [7:0] DETECT_OPCODE  = 8'h65;
	localparam logic [1:0] ADDR_LEN_VAR   = 2'h3;
	localparam logic [1:0] RSV_HI_ONES    = 2'h3;
	localparam logic [3:0] LATENCY_VAR    = 4'hf;
	localparam logic [5:0] RSV_LO_ONES    = 6'h3f;
	localparam logic       DESC_IS_CMD    = 1'h0;
	localparam logic       DESC_NOT_END   = 1'h0;
	localparam logic       DESC_IS_END    = 1'h1;
	localparam int         MASK_LSB       = 24;
	localparam int         OPCODE_LSB     = 8;
	localparam int         TYPE_BIT       = 1;
	localparam int         END_BIT        = 0;

	localparam logic [7:0]  MASK_MAP_STYLE = 8'h08;
	localparam logic [7:0]  MASK_PLACEMENT = 8'h04;
	localparam logic [7:0]  MASK_SIZE      = 8'h02;
	localparam logic [31:0] ADDR_CFG3      = 32'h0000_0004;
	localparam logic [31:0] ADDR_CFG1      = 32'h0000_0002;
	localparam logic [7:0]  UNMAPPED_BYTE  = 8'hff;

	// ********************************************************************
	// Table geometry
	// ********************************************************************
	localparam int IDX_W      = 3;
	localparam int TBL_DEPTH  = 6;
	localparam int INDEX_W    = 3;
	localparam logic [INDEX_W-1:0] MAX_INDEX = 3'h5;

	function automatic logic [31:0] smd_cmd_desc(input logic [7:0] mask, input logic last);
		smd_cmd_desc = {mask, ADDR_LEN_VAR, RSV_HI_ONES, LATENCY_VAR, DETECT_OPCODE,
			RSV_LO_ONES, DESC_IS_CMD, last};
	endfunction : smd_cmd_desc

	localparam logic [31:0] DESC_TABLE [TBL_DEPTH] = '{
		smd_cmd_desc(MASK_MAP_STYLE, DESC_NOT_END),
		ADDR_CFG3,
		smd_cmd_desc(MASK_PLACEMENT, DESC_NOT_END),
		ADDR_CFG1,
		smd_cmd_desc(MASK_SIZE, DESC_IS_END),
		ADDR_CFG3
	};

	// ********************************************************************
	// Controller registers on APB
	// ********************************************************************
	localparam int         APB_ADDR_W     = 8;
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam int         CTRL_START_BIT = 0;
	localparam int         ST_BUSY        = 0;
	localparam int         ST_DONE        = 1;
	localparam int         ST_ERR         = 2;
	localparam int         ST_IDX_LSB     = 4;
	localparam int         ST_UNIFORM     = 8;
	localparam int         ST_TOP         = 9;
	localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

	typedef enum logic [1:0] {
		SMD_IDLE       = 2'h0,
		SMD_FETCH_CMD  = 2'h1,
		SMD_FETCH_ADDR = 2'h3,
		SMD_READ_REG   = 2'h2
	} smd_state_t;

endpackage : smd_pkg
`default_nettype wire

/* File: verification/smd_props.sv */
// Checker of the detection link between the host and device ends
`timescale 1ns/1ns
`default_nettype none
module smd_props (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      tbl_req,
	input wire logic [smd_pkg::IDX_W-1:0] tbl_idx,
	input wire logic                      tbl_ack,
	input wire logic [31:0]               tbl_data,
	input wire logic                      reg_req,
	input wire logic [7:0]                reg_op,
	input wire logic [31:0]               reg_addr,
	input wire logic                      reg_ack
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ********************************************************************
	// Descriptor steps
	// ********************************************************************
	sequence s_cmd;
		tbl_ack && !tbl_idx[0];
	endsequence
	sequence s_addr1;
		tbl_ack && tbl_idx == 3'h1;
	endsequence
	sequence s_addr2;
		tbl_ack && tbl_idx == 3'h3;
	endsequence

	// ********************************************************************
	// Checks
	// ********************************************************************
	addr_len_a: assert property (s_cmd |-> tbl_data[23:22] == 2'h3)
		else $error("address length field wrong");
	latency_a: assert property (s_cmd |-> tbl_data[19:16] == 4'hf)
		else $error("latency field wrong");
	opcode_a: assert property (s_cmd |-> tbl_data[15:8] == 8'h65)
		else $error("detection opcode wrong");
	reserved_a: assert property (
		s_cmd |-> tbl_data[21:20] == 2'h3 && tbl_data[7:2] == 6'h3f)
		else $error("reserved field not ones");
	cmd_type_a: assert property (s_cmd |-> !tbl_data[1])
		else $error("descriptor type bit set");
	first_mask_a: assert property (
		tbl_ack && tbl_idx == 3'h0 |-> tbl_data[31:24] == 8'h08 && !tbl_data[0])
		else $error("first descriptor mask or end bit wrong");
	second_mask_a: assert property (
		tbl_ack && tbl_idx == 3'h2 |-> tbl_data[31:24] == 8'h04 && !tbl_data[0])
		else $error("second descriptor mask or end bit wrong");
	first_addr_a: assert property (
		s_addr1 |-> (tbl_data == 32'h0000_0004)
		##[1:8] (reg_req && reg_op == 8'h65 && reg_addr == 32'h0000_0004))
		else $error("first register read address wrong");
	second_addr_a: assert property (
		s_addr2 |-> (tbl_data == 32'h0000_0002)
		##[1:8] (reg_req && reg_op == 8'h65 && reg_addr == 32'h0000_0002))
		else $error("second register read address wrong");
	tbl_answer_a: assert property (tbl_req && !tbl_ack |=> tbl_ack ##1 !tbl_ack)
		else $error("table read not answered in one cycle");
	reg_answer_a: assert property (reg_req && !reg_ack |=> reg_ack ##1 !reg_ack)
		else $error("register read not answered in one cycle");
endmodule : smd_props
`default_nettype wire

/* File: verification/smd_tb.sv */
// Testbench driving the host over APB with the device end attached
`timescale 1ns/1ns
`default_nettype none
module sector_map_detect_table_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic [7:0]  paddr;
	logic [7:0]  cfg3;
	logic [7:0]  cfg1;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	int          num_errors;
	int          cmp_count;

	smd_link_if i_smd_link_if ();
	smd_device i_smd_device (.pclk(pclk), .presetn(presetn), .link(i_smd_link_if),
		.third_nonvolatile_config_reg(cfg3), .first_nonvolatile_config_reg(cfg1));
	smd_host i_smd_host (.pclk(pclk), .presetn(presetn), .link(i_smd_link_if),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	smd_props i_smd_props (.pclk(pclk), .presetn(presetn),
		.tbl_req(i_smd_link_if.tbl_req), .tbl_idx(i_smd_link_if.tbl_idx),
		.tbl_ack(i_smd_link_if.tbl_ack), .tbl_data(i_smd_link_if.tbl_data),
		.reg_req(i_smd_link_if.reg_req), .reg_op(i_smd_link_if.reg_op),
		.reg_addr(i_smd_link_if.reg_addr), .reg_ack(i_smd_link_if.reg_ack));

	// ********************************************************************
	// Tasks
	// ********************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// ********************************************************************
	// Stimulus
	// ********************************************************************
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		print_verdict();
	end

	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cfg3 = 8'h00;
		cfg1 = 8'h00;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h1, 8'h08, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		$display("test unmapped done");
		// Neighbour bits stay fixed while the selected ones follow i, to expose a wrong mask
		for (int i = 0; i < 8; i++)
		begin
			cfg3 <= {4'hf, i[2], 1'h1, i[0], 1'h0};
			cfg1 <= {5'h1a, i[1], 2'h3};
			apb(1'h1, 8'h00, 32'h1);
			repeat (100)
			begin
				apb(1'h0, 8'h04, 32'h0);
				if (rd[0] === 1'h0)
					break;
			end
			if (i < 6)
			begin
				chk(rd & 32'h77, {25'h0, i[2:0], 4'h2});
				chk(rd & 32'h300, {22'h0, i[1], i[2], 8'h0});
			end
			else
				chk(rd & 32'h5, 32'h4);
			$display("test config %0d done", i);
		end
		print_verdict();
	end
endmodule : sector_map_detect_table_tb
`default_nettype wire
